// >>> core/pin_func_pkg.sv
package pin_func_pkg;
   // decoded bus access strobes, all active high
   typedef struct packed {
      logic rd_stb;
      logic wr_stb;
      logic access;
   } bus_ctl_t;
   // hardware-mode static configuration
   typedef struct packed {
      logic zero_subst_coding_enable;
      logic rx_mode_sel_bit2;
      logic remote_loopback_pin;
      logic clk_prescale_sel_bit1;
      logic tx_mode_sel_bit3;
   } hw_cfg_t;
endpackage

// >>> core/pin_func_regs.svh
`ifndef PIN_FUNC_REGS_SVH
`define PIN_FUNC_REGS_SVH
`define SEL_MUXED    2'h0
`define SEL_NONMUXED 2'h1
`define SEL_SERIAL   2'h2
`define SEL_HARDWARE 2'h3
`define ADDR_RST     8'h00
`define MODE_RST     4'h0
`define RST_SYNC_CLR 2'h0
// control pins idle: read, chip select and write high, latch low
`define PIN_IDLE     6'h0d
`define SEL_RST      2'h0
`define ALO_RST      7'h00
`define AD_RST       8'h00
`define ALE_IDLE     1'h0
`endif

// >>> core/pin_func_select.sv
`timescale 1ns/10ps
`include "pin_func_regs.svh"
module pin_func_select
(
   input  wire logic                 core_clk_i,                // 50 MHz core clock
   input  wire logic                 rstn_i,                    // async reset, active low
   input  wire logic [1:0]           interface_select_strap_i,  // port personality strap
   input  wire logic                 bus_timing_style_select_i, // bus timing / coding pin
   input  wire logic                 rd_pin_i,                  // read / data strobe pin
   input  wire logic                 cs_n_pin_i,                // chip select pin
   input  wire logic                 ale_pin_i,                 // latch / A7 / prescale pin
   input  wire logic                 wr_pin_i,                  // write / direction pin
   input  wire logic [6:0]           addr_low_i,                // address bits 6..0 (non-mux)
   input  wire logic [7:0]           ad_bus_i,                  // shared address/data bus
   input  wire logic                 tx_rx_same_mode_i,         // tx and rx modes match
   output logic [7:0]                addr_o,                    // current access address
   output pin_func_pkg::bus_ctl_t    bus_ctl_o,                 // decoded strobes
   output pin_func_pkg::hw_cfg_t     hw_cfg_o,                  // hardware-mode levels
   output logic                      hw_mode_o,                 // hardware mode active
   output logic                      serial_mode_o              // serial port active
);

   // ******************************
   // reset release and pin sync
   // ******************************
   logic [1:0] rst_sync_reg;   // reset release shift register
   logic       rst_n;          // released reset, active low
   // pins are asynchronous; two flops before any logic reads them
   logic [5:0] pin_s1_reg;     // control pins, first stage
   logic [5:0] pin_s2_reg;     // control pins, second stage
   logic [1:0] sel_s1_reg;     // personality strap, first stage
   logic [1:0] sel_s2_reg;     // personality strap, second stage
   logic [6:0] alo_s1_reg;     // low address pins, first stage
   logic [6:0] alo_s2_reg;     // low address pins, second stage
   logic [7:0] ad_s1_reg;      // shared bus, first stage
   logic [7:0] ad_s2_reg;      // shared bus, second stage
   logic       ale_last_reg;   // latch pin one cycle back

   // assert at once, release two edges later so no flop leaves reset mid-edge
   always_ff @(posedge core_clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         rst_sync_reg <= `RST_SYNC_CLR;
      else
         rst_sync_reg <= {rst_sync_reg[0], 1'h1};
   end
   assign rst_n = rst_sync_reg[1];

   // control pins; idle host levels on reset, so no access shows after release
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_reg <= `PIN_IDLE;
         pin_s2_reg <= `PIN_IDLE;
      end
      else
      begin
         pin_s1_reg <= {tx_rx_same_mode_i, bus_timing_style_select_i, rd_pin_i,
                        cs_n_pin_i, ale_pin_i, wr_pin_i};
         pin_s2_reg <= pin_s1_reg;
      end
   end

   // personality strap; same depth as the control pins so both change together
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sel_s1_reg <= `SEL_RST;
         sel_s2_reg <= `SEL_RST;
      end
      else
      begin
         sel_s1_reg <= interface_select_strap_i;
         sel_s2_reg <= sel_s1_reg;
      end
   end

   // low address pins, read only in non-multiplexed mode
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         alo_s1_reg <= `ALO_RST;
         alo_s2_reg <= `ALO_RST;
      end
      else
      begin
         alo_s1_reg <= addr_low_i;
         alo_s2_reg <= alo_s1_reg;
      end
   end

   // shared bus; a word that moves as the latch pin rises may tear, host holds it
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ad_s1_reg <= `AD_RST;
         ad_s2_reg <= `AD_RST;
      end
      else
      begin
         ad_s1_reg <= ad_bus_i;
         ad_s2_reg <= ad_s1_reg;
      end
   end

   // ******************************
   // decode helpers
   // ******************************
   // true when the synchronised strap holds the given personality code
   function automatic logic sel_is(input logic [1:0] sel_val,
                                   input logic [1:0] code);
      return (sel_val == code);
   endfunction

   // a strobe counts only for a selected parallel-port access
   function automatic logic bus_gate(input logic acc,
                                     input logic ser,
                                     input logic term);
      return acc & ~ser & term;
   endfunction

   // ******************************
   // pin decode
   // ******************************
   logic [1:0] sel;          // synchronised strap
   logic       same_mode;    // tx and rx modes match
   logic       bus_timing_style_select;          // bus timing pin
   logic       rd_p;         // read / data strobe pin
   logic       cs_n;         // chip select pin, active low
   logic       ale;          // latch / bit 7 / prescale pin
   logic       wr_p;         // write / direction pin
   logic       hw;           // hardware personality
   logic       muxed;        // multiplexed parallel bus
   logic       nonmux;       // non-multiplexed parallel bus
   logic       serial;       // serial port
   logic       strobe_act;   // read or data strobe asserted
   logic       access;       // chip selected outside hardware mode
   logic       rd_stb;       // decoded read
   logic       wr_stb;       // decoded write

   assign {same_mode, bus_timing_style_select, rd_p, cs_n, ale, wr_p} = pin_s2_reg;
   assign sel    = sel_s2_reg;
   assign hw     = sel_is(sel, `SEL_HARDWARE);
   assign muxed  = sel_is(sel, `SEL_MUXED);
   assign nonmux = sel_is(sel, `SEL_NONMUXED);
   assign serial = sel_is(sel, `SEL_SERIAL);

   // data strobe polarity flips in non-multiplexed mode
   assign strobe_act = (bus_timing_style_select && nonmux) ? rd_p : ~rd_p;
   // hardware mode never produces bus accesses
   assign access = ~hw & ~cs_n;
   // strobe/direction timing vs separate read and write strobes
   assign rd_stb = bus_gate(access, serial,
                            bus_timing_style_select ? (strobe_act & wr_p) : strobe_act);
   assign wr_stb = bus_gate(access, serial,
                            bus_timing_style_select ? (strobe_act & ~wr_p) : ~wr_p);

   // ******************************
   // address capture
   // ******************************
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         ale_last_reg <= `ALE_IDLE;                         // idle level, no false edge
      else
         ale_last_reg <= ale;
   end

   // muxed: latch on rising edge of the latch pin; non-muxed: follow pins
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         addr_o <= `ADDR_RST;
      else if (muxed && ale && !ale_last_reg)
         addr_o <= ad_s2_reg;
      else if (nonmux)
         addr_o <= {ale, alo_s2_reg};
   end

   // ******************************
   // registered outputs
   // ******************************
   // strobes leave through one register, so decode glitches never reach the port
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         bus_ctl_o <= '0;
      else
         bus_ctl_o <= '{rd_stb: rd_stb, wr_stb: wr_stb, access: access};
   end

   // hardware personality flag
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         hw_mode_o <= 1'h0;
      else
         hw_mode_o <= hw;
   end

   // serial personality flag
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         serial_mode_o <= 1'h0;
      else
         serial_mode_o <= serial;
   end

   // static levels only while in hardware mode, cleared otherwise
   always_ff @(posedge core_clk_i or negedge rst_n)
   begin
      if (!rst_n)
         hw_cfg_o <= '0;
      else if (hw)
      begin
         hw_cfg_o.zero_subst_coding_enable <= bus_timing_style_select;
         hw_cfg_o.rx_mode_sel_bit2         <= rd_p;
         hw_cfg_o.remote_loopback_pin      <= cs_n & same_mode;
         hw_cfg_o.clk_prescale_sel_bit1    <= ale;
         hw_cfg_o.tx_mode_sel_bit3         <= wr_p;
      end
      else
         hw_cfg_o <= '0;
   end

endmodule

// >>> sim/host_pins_model.sv
`timescale 1ns/10ps
module host_pins_model
(
   input  wire logic        core_clk_i, // clock
   input  wire logic [22:0] req_i,      // wanted levels
   output logic      [22:0] pins_o      // pin levels
);
   // host holds select, strobes and straps between falling edges
   initial pins_o = 23'h000000;
   always @(negedge core_clk_i) pins_o <= req_i;
endmodule

// >>> sim/pin_func_select_assertions.sv
`timescale 1ns/10ps
module pin_func_select_assertions
(
   input wire logic                   core_clk_i,                // clock
   input wire logic                   rstn_i,                    // reset
   input wire logic [1:0]             interface_select_strap_i,  // strap
   input wire logic                   bus_timing_style_select_i, // timing
   input wire logic                   rd_pin_i,                  // read
   input wire logic                   cs_n_pin_i,                // select
   input wire logic                   ale_pin_i,                 // latch
   input wire logic                   wr_pin_i,                  // write
   input wire logic [6:0]             addr_low_i,                // addr
   input wire logic                   tx_rx_same_mode_i,         // match
   input wire logic [7:0]             addr_o,                    // addr
   input wire pin_func_pkg::bus_ctl_t bus_ctl_o,                 // strobes
   input wire pin_func_pkg::hw_cfg_t  hw_cfg_o,                  // levels
   input wire logic                   hw_mode_o,                 // hw
   input wire logic                   serial_mode_o              // serial
);
   logic [14:0] d1, d2, d3;
   logic [3:0]  up;
   // pins as the outputs see them, three edges late
   always_ff @(posedge core_clk_i)
      {d3, d2, d1} <= {d2, d1, interface_select_strap_i, bus_timing_style_select_i, rd_pin_i,
         cs_n_pin_i, ale_pin_i, wr_pin_i, tx_rx_same_mode_i, addr_low_i};
   // settle window, since the delay line still holds reset-time pins
   always_ff @(posedge core_clk_i or negedge rstn_i)
      if (!rstn_i) up <= 4'h0;
      else if (!up[3]) up <= up + 4'h1;
   wire [1:0] s = d3[14:13];
   wire b = d3[12], r = d3[11], c = d3[10], l = d3[9], w = d3[8], m = d3[7], ok = up[3];
   wire ds = !c && (r == (s == 2'h1));
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rstn_i);
   sequence mux_quiet_s;
      (interface_select_strap_i == 2'h0 && !ale_pin_i)[*6];
   endsequence
   mode_flags_a: assert property (ok |-> {hw_mode_o, serial_mode_o} == {s == 2'h3, s == 2'h2})
      else $error("mode flags wrong");
   access_gate_a: assert property (ok |-> bus_ctl_o.access == (!c && s != 2'h3))
      else $error("access wrong");
   sep_strobe_a: assert property (ok && !s[1] && !b |-> bus_ctl_o[2:1] == {!c & !r, !c & !w})
      else $error("read write strobes wrong");
   ds_strobe_a: assert property (ok && !s[1] && b |-> bus_ctl_o[2:1] == {ds & w, ds & !w})
      else $error("data strobe decode wrong");
   serial_strobe_a: assert property (ok && s == 2'h2 |-> bus_ctl_o[2:1] == 2'h0)
      else $error("serial strobes set");
   hw_levels_a:
      assert property (ok |-> hw_cfg_o == (s == 2'h3 ? {b, r, c & m, l, w} : 5'h00))
      else $error("hardware levels wrong");
   addr_nonmux_a: assert property (ok && s == 2'h1 |-> addr_o == {l, d3[6:0]})
      else $error("nonmux address wrong");
   addr_hold_a: assert property (ok ##0 mux_quiet_s |-> $stable(addr_o))
      else $error("address moved without latch");
endmodule
bind pin_func_select pin_func_select_assertions pin_func_select_assertions_inst (.*);

// >>> sim/pin_func_select_tb.sv
`timescale 1ns/10ps
module pin_func_select_tb;
   logic core_clk_i = 1'b0, rstn_i = 1'b0, hw_mode_o, serial_mode_o;
   logic [22:0] req = 23'h000000, pins;
   wire logic [1:0] interface_select_strap_i;
   wire logic bus_timing_style_select_i, rd_pin_i, cs_n_pin_i, ale_pin_i, wr_pin_i;
   wire logic tx_rx_same_mode_i;
   wire logic [6:0] addr_low_i;
   wire logic [7:0] ad_bus_i;
   logic [7:0] addr_o;
   pin_func_pkg::bus_ctl_t bus_ctl_o;
   pin_func_pkg::hw_cfg_t hw_cfg_o;
   int fails = 0, n_compared = 0;
   assign {interface_select_strap_i, bus_timing_style_select_i, rd_pin_i, cs_n_pin_i, ale_pin_i,
      wr_pin_i, tx_rx_same_mode_i, addr_low_i, ad_bus_i} = pins;
   always #10 core_clk_i = ~core_clk_i;
   host_pins_model host_pins_model_inst (.core_clk_i(core_clk_i), .req_i(req), .pins_o(pins));
   pin_func_select pin_func_select_inst (.*);
   // strobe, mode and level outputs for one pin pattern
   function automatic logic [9:0] expect_of(input logic [22:0] v);
      logic [1:0] s;
      logic b, r, c, l, w, m, ds, par;
      {s, b, r, c, l, w, m} = v[22:15];
      ds = !c && (r == (s == 2'h1)) && !s[1];
      par = !s[1] && !c;
      return {b ? ds & w : par & !r, b ? ds & !w : par & !w, !c && s != 2'h3,
         s == 2'h3 ? {b, r, c & m, l, w} : 5'h00, s == 2'h3, s == 2'h2};
   endfunction
   task automatic chk(input logic [9:0] got, input logic [9:0] want);
      n_compared++;
      if (got !== want)
      begin
         fails++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, want);
      end
   endtask
   task automatic chk_addr(input logic [7:0] got, input logic [7:0] want);
      n_compared++;
      if (got !== want)
      begin
         fails++;
         $display("CHECK FAILED at %0t: address got %h want %h", $time, got, want);
      end
   endtask
   task automatic give_verdict();
      $display("compared %0d, fails %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // hold a pattern long enough to pass the synchronisers, then compare
   task automatic put(input logic [22:0] v);
      @(negedge core_clk_i) req <= v;
      repeat (6) @(negedge core_clk_i);
      chk({bus_ctl_o, hw_cfg_o, hw_mode_o, serial_mode_o}, expect_of(v));
      if (v[22:21] == 2'h1) chk_addr(addr_o, {v[17], v[14:8]});
   endtask
   initial
   begin
      void'($urandom(55));
      repeat (4) @(negedge core_clk_i);
      rstn_i = 1'b1;
      for (int i = 0; i < 8; i++) put({i[2:0], 20'h00000});
      repeat (300) put(23'($urandom));
      // latch edge takes the bus, later bus traffic is ignored
      put(23'h00003c);
      put(23'h0200a5);
      put(23'h00005a);
      chk_addr(addr_o, 8'ha5);
      // outputs looked at a full cycle into the reset pulse, not in its own step
      @(negedge core_clk_i) rstn_i = 1'b0;
      @(negedge core_clk_i) chk({bus_ctl_o, hw_cfg_o, hw_mode_o, serial_mode_o}, 10'h000);
      rstn_i = 1'b1;
      repeat (40) put(23'($urandom));
      give_verdict();
   end
   // watchdog, far beyond the expected run of about 50 us
   initial
   begin
      #200000;
      fails++;
      give_verdict();
   end
endmodule
